// ===== rtl/csp_regs.sv
/*
 Control register slice of a clock synthesizer: latched divider resets,
 system PLL settings and digital loop control, with tuning word selection.
 Assumes a decoded serial port delivering byte writes and reads on clock.
*/
// Function
// - Bit 7 powers down fundamental, spurs stay
// - Bits 3,2 hold prescalers in async reset
// - Bits 1,0 reset dividers at prescaler edge
// - Latched reset bits hold until rewritten
// - Feedback ratio from five-bit field, zero gives four
// - Auto range bit lets hardware pick VCO band
// - Bit 3 enables reference doubler
// - Bit 2 selects low or high VCO
// - Phase detector clock is system clock/(field*4)
// - Single tone outputs first tuning word open loop
// - Bit 4 disables estimator; result readable only while enabled
// - Bit 3 enables slew limiter with limits
// - Bit 1 inverts loop polarity
// - Bit 0 closes loop, uses estimate if enabled
// - Autoclear filter and integrator reset pulses
`timescale 1ns/1ps
module csp_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register access port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	// Device status inputs
	input wire logic vco_auto_high,
	input wire logic fb_prescaler_out,
	input wire logic ref_prescaler_out,
	input wire logic [47:0] first_tuning_word,
	input wire logic [47:0] loop_tuning_word,
	input wire logic [47:0] freq_estimate,
	// Control outputs
	output csp_pkg::csp_ctrl_t pll_ctrl,
	output csp_pkg::csp_clr_t clr_pulse,
	output logic pd_clk_tick,
	output logic [47:0] dds_tuning_word,
	output logic [47:0] slew_limits
);

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
		hit = (a == ref_a);
	endfunction

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
			input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Byte offset inside a multi-byte field
	function automatic logic [2:0] byte_idx(input logic [15:0] a, input logic [15:0] first);
		byte_idx = 3'(a - first);
	endfunction

	logic [7:0] latched_r;
	logic [7:0] fb_ratio_r;
	logic [7:0] params_r;
	logic [7:0] pd_div_r;
	logic [7:0] loop_r;
	logic [7:0] slew_r [csp_pkg::SLEW_BYTES];
	logic [7:0] autoclr_nxt;
	logic vco_high_nxt;
	logic fb_presc_d_r;
	logic ref_presc_d_r;
	logic fb_div_rst_r;
	logic ref_div_rst_r;
	logic [5:0] pd_ratio;
	logic [5:0] pd_cnt_r;
	logic [7:0] rdata_nxt;
	logic [47:0] ftw_nxt;
	logic [7:0] fest_byte [csp_pkg::FEST_BYTES];

	// Latched resets keep their value until the next write
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			latched_r <= csp_pkg::RST_LATCHED;
		end else if (reg_wr && hit(reg_addr, csp_pkg::ADDR_LATCHED_RESETS)) begin
			latched_r <= reg_wdata & csp_pkg::MASK_LATCHED;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fb_ratio_r <= csp_pkg::RST_FB_RATIO;
		end else if (reg_wr && hit(reg_addr, csp_pkg::ADDR_FB_RATIO)) begin
			fb_ratio_r <= reg_wdata & csp_pkg::MASK_FB_RATIO;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			params_r <= csp_pkg::RST_PLL_PARAMS;
		end else if (reg_wr && hit(reg_addr, csp_pkg::ADDR_PLL_PARAMS)) begin
			params_r <= reg_wdata & csp_pkg::MASK_PLL_PARAMS;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pd_div_r <= csp_pkg::RST_PD_CLK_DIV;
		end else if (reg_wr && hit(reg_addr, csp_pkg::ADDR_PD_CLK_DIV)) begin
			pd_div_r <= reg_wdata & csp_pkg::MASK_PD_CLK_DIV;
		end
	end

	// Single tone with the loop closed is not policed here; the tone wins
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			loop_r <= csp_pkg::RST_LOOP_CTRL;
		end else if (reg_wr && hit(reg_addr, csp_pkg::ADDR_LOOP_CTRL)) begin
			loop_r <= reg_wdata & csp_pkg::MASK_LOOP_CTRL;
		end
	end

	// Slew limit bytes, lowest address is the least significant byte
	genvar gi;
	generate
		for (gi = 0; gi < csp_pkg::SLEW_BYTES; gi++) begin : g_slew
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					slew_r[gi] <= csp_pkg::RST_SLEW_BYTE;
				end else if (reg_wr && hit(reg_addr,
						csp_pkg::ADDR_SLEW_FIRST + 16'(gi))) begin
					slew_r[gi] <= reg_wdata;
				end
			end
			assign slew_limits[gi*8 +: 8] = slew_r[gi];
		end
	endgenerate

	// Estimator bytes, lowest address is the least significant byte
	generate
		for (gi = 0; gi < csp_pkg::FEST_BYTES; gi++) begin : g_fest
			assign fest_byte[gi] = freq_estimate[gi*8 +: 8];
		end
	endgenerate

	// Autoclearing resets: one-cycle pulse per written one, except bit 6
	always_comb begin
		autoclr_nxt = 8'h00;
		if (reg_wr && hit(reg_addr, csp_pkg::ADDR_AUTOCLR_RESETS)) begin
			autoclr_nxt = reg_wdata & csp_pkg::MASK_AUTOCLR;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			clr_pulse <= '0;
		end else begin
			clr_pulse.all_bits <= autoclr_nxt;
			clr_pulse.loop_filter_stage <= autoclr_nxt[csp_pkg::BIT_LF_RESET];
			clr_pulse.comb_integrator_stage <= autoclr_nxt[csp_pkg::BIT_CCI_RESET];
		end
	end

	// VCO band: hardware choice overrides the written bit in auto mode
	always_comb begin
		vco_high_nxt = params_r[csp_pkg::BIT_VCO_HIGH];
		if (params_r[csp_pkg::BIT_VCO_AUTO]) begin
			vco_high_nxt = vco_auto_high;
		end
	end

	// Integer divider resets change only at a prescaler output rising edge
	// Prescaler outputs are sampled, so they must toggle slower than half the clock
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fb_presc_d_r <= 1'b0;
			ref_presc_d_r <= 1'b0;
		end else begin
			fb_presc_d_r <= fb_prescaler_out;
			ref_presc_d_r <= ref_prescaler_out;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fb_div_rst_r <= 1'b0;
		end else if (fb_prescaler_out && !fb_presc_d_r) begin
			fb_div_rst_r <= latched_r[csp_pkg::BIT_FB_DIV_RST];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ref_div_rst_r <= 1'b0;
		end else if (ref_prescaler_out && !ref_presc_d_r) begin
			ref_div_rst_r <= latched_r[csp_pkg::BIT_REF_DIV_RST];
		end
	end

	// Phase detector clock divider; a zero field stops the tick
	assign pd_ratio = 6'(pd_div_r[3:0]) << csp_pkg::PD_DIV_SCALE_SHIFT;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pd_cnt_r <= 6'h00;
			pd_clk_tick <= 1'b0;
		end else if (pd_ratio == 6'h00) begin
			pd_cnt_r <= 6'h00;
			pd_clk_tick <= 1'b0;
		end else if (pd_cnt_r >= pd_ratio - 6'h01) begin
			pd_cnt_r <= 6'h00;
			pd_clk_tick <= 1'b1;
		end else begin
			pd_cnt_r <= pd_cnt_r + 6'h01;
			pd_clk_tick <= 1'b0;
		end
	end

	// Control outputs from flops
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pll_ctrl <= '0;
		end else begin
			pll_ctrl.fund_powerdown <= latched_r[csp_pkg::BIT_FUND_PD];
			pll_ctrl.fb_prescaler_rst <= latched_r[csp_pkg::BIT_FB_PRESC_RST];
			pll_ctrl.ref_prescaler_rst <= latched_r[csp_pkg::BIT_REF_PRESC_RST];
			pll_ctrl.fb_divider_rst <= fb_div_rst_r;
			pll_ctrl.ref_divider_rst <= ref_div_rst_r;
			pll_ctrl.fb_ratio <= {fb_ratio_r[4:0], 1'b0}
				+ {csp_pkg::FB_RATIO_OFFSET[5:0], 1'b0};
			pll_ctrl.ref_doubler_en <= params_r[csp_pkg::BIT_REF_DOUBLER];
			pll_ctrl.vco_high_range <= vco_high_nxt;
			pll_ctrl.pd_clk_ratio <= pd_ratio;
			pll_ctrl.single_tone <= loop_r[csp_pkg::BIT_SINGLE_TONE];
			pll_ctrl.estimator_en <= !loop_r[csp_pkg::BIT_FEST_DISABLE];
			pll_ctrl.slew_limit_en <= loop_r[csp_pkg::BIT_SLEW_EN];
			pll_ctrl.loop_invert <= loop_r[csp_pkg::BIT_POLARITY];
			pll_ctrl.loop_closed <= loop_r[csp_pkg::BIT_LOOP_CLOSE];
			pll_ctrl.use_estimate <= loop_r[csp_pkg::BIT_LOOP_CLOSE]
				&& !loop_r[csp_pkg::BIT_FEST_DISABLE];
		end
	end

	// Tuning word to the synthesizer core
	// Registered so the core never sees a half-switched word
	always_comb begin
		ftw_nxt = loop_tuning_word;
		if (loop_r[csp_pkg::BIT_SINGLE_TONE]) begin
			ftw_nxt = first_tuning_word;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dds_tuning_word <= 48'h000000000000;
		end else begin
			dds_tuning_word <= ftw_nxt;
		end
	end

	// Read mux; unmapped and autoclear addresses read zero
	// A read alongside a write to the same address returns the old value
	always_comb begin
		rdata_nxt = 8'h00;
		case (1'b1)
			hit(reg_addr, csp_pkg::ADDR_LATCHED_RESETS): rdata_nxt = latched_r;
			hit(reg_addr, csp_pkg::ADDR_FB_RATIO): rdata_nxt = fb_ratio_r;
			hit(reg_addr, csp_pkg::ADDR_PLL_PARAMS): begin
				rdata_nxt = params_r;
				rdata_nxt[csp_pkg::BIT_VCO_HIGH] = vco_high_nxt;
			end
			hit(reg_addr, csp_pkg::ADDR_PD_CLK_DIV): rdata_nxt = pd_div_r;
			hit(reg_addr, csp_pkg::ADDR_LOOP_CTRL): rdata_nxt = loop_r;
			in_range(reg_addr, csp_pkg::ADDR_FEST_FIRST, csp_pkg::ADDR_FEST_LAST): begin
				if (!loop_r[csp_pkg::BIT_FEST_DISABLE]) begin
					rdata_nxt = fest_byte[byte_idx(reg_addr, csp_pkg::ADDR_FEST_FIRST)];
				end
			end
			in_range(reg_addr, csp_pkg::ADDR_SLEW_FIRST, csp_pkg::ADDR_SLEW_LAST): begin
				rdata_nxt = slew_r[byte_idx(reg_addr, csp_pkg::ADDR_SLEW_FIRST)];
			end
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_nxt;
			end
		end
	end

endmodule

// ===== rtl/csp_pkg.sv
/*
 Constants and carrier types for the clock synthesizer PLL control registers.
 Assumes an 8-bit register access port decoded from the serial control port.
*/
package csp_pkg;
	// Register addresses
	localparam logic [15:0] ADDR_AUTOCLR_RESETS = 16'h0012;
	localparam logic [15:0] ADDR_LATCHED_RESETS = 16'h0013;
	localparam logic [15:0] ADDR_FB_RATIO = 16'h0020;
	localparam logic [15:0] ADDR_RSVD_SYSTEM_CLOCK_INPUT = 16'h0021;
	localparam logic [15:0] ADDR_PLL_PARAMS = 16'h0022;
	localparam logic [15:0] ADDR_PD_CLK_DIV = 16'h0023;
	localparam logic [15:0] ADDR_LOOP_CTRL = 16'h0100;
	localparam logic [15:0] ADDR_FEST_FIRST = 16'h0115;
	localparam logic [15:0] ADDR_FEST_LAST = 16'h011A;
	localparam logic [15:0] ADDR_SLEW_FIRST = 16'h0127;
	localparam logic [15:0] ADDR_SLEW_LAST = 16'h012C;
	localparam int SLEW_BYTES = 6;
	localparam int FEST_BYTES = 6;

	// Writable bit masks, reserved bits stay zero
	localparam logic [7:0] MASK_AUTOCLR = 8'hBF;
	localparam logic [7:0] MASK_LATCHED = 8'h8F;
	localparam logic [7:0] MASK_FB_RATIO = 8'h1F;
	localparam logic [7:0] MASK_PLL_PARAMS = 8'h8F;
	localparam logic [7:0] MASK_PD_CLK_DIV = 8'h0F;
	localparam logic [7:0] MASK_LOOP_CTRL = 8'h3B;

	// Field positions
	localparam int BIT_FUND_PD = 7;
	localparam int BIT_FB_PRESC_RST = 3;
	localparam int BIT_REF_PRESC_RST = 2;
	localparam int BIT_FB_DIV_RST = 1;
	localparam int BIT_REF_DIV_RST = 0;
	localparam int BIT_VCO_AUTO = 7;
	localparam int BIT_REF_DOUBLER = 3;
	localparam int BIT_VCO_HIGH = 2;
	localparam int BIT_SINGLE_TONE = 5;
	localparam int BIT_FEST_DISABLE = 4;
	localparam int BIT_SLEW_EN = 3;
	localparam int BIT_POLARITY = 1;
	localparam int BIT_LOOP_CLOSE = 0;
	localparam int BIT_LF_RESET = 2;
	localparam int BIT_CCI_RESET = 1;

	// Values after reset
	localparam logic [7:0] RST_LATCHED = 8'h00;
	localparam logic [7:0] RST_FB_RATIO = 8'h00;
	localparam logic [7:0] RST_PLL_PARAMS = 8'h00;
	localparam logic [7:0] RST_PD_CLK_DIV = 8'h00;
	localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
	localparam logic [7:0] RST_SLEW_BYTE = 8'h00;

	// Feedback ratio: fixed divide-by-two ahead of field plus offset
	localparam logic [6:0] FB_RATIO_OFFSET = 7'h02;
	localparam int PD_DIV_SCALE_SHIFT = 2;

	typedef struct packed {
		logic fund_powerdown;
		logic fb_prescaler_rst;
		logic ref_prescaler_rst;
		logic fb_divider_rst;
		logic ref_divider_rst;
		logic [6:0] fb_ratio;
		logic ref_doubler_en;
		logic vco_high_range;
		logic [5:0] pd_clk_ratio;
		logic single_tone;
		logic estimator_en;
		logic slew_limit_en;
		logic loop_invert;
		logic loop_closed;
		logic use_estimate;
	} csp_ctrl_t;

	typedef struct packed {
		logic loop_filter_stage;
		logic comb_integrator_stage;
		logic [7:0] all_bits;
	} csp_clr_t;
endpackage

// ===== tb/csp_regs_sva.sv
/* Port checker for the control register slice.
 Bound to csp_regs from the bench top file. */
`timescale 1ns/1ps
module csp_regs_sva (
	// Clock, reset and register port
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	// Controls
	input wire csp_pkg::csp_ctrl_t pll_ctrl,
	input wire csp_pkg::csp_clr_t clr_pulse,
	input wire logic [47:0] first_tuning_word,
	input wire logic [47:0] dds_tuning_word
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_wr(logic [15:0] a);
		reg_wr && reg_addr == a;
	endsequence
	// Write lands in the register, controls follow one edge later
	a_read_valid: assert property (reg_rd |=> reg_rd_valid)
		else $error("read answer missing");
	a_valid_pulse: assert property (!reg_rd |=> !reg_rd_valid)
		else $error("read valid without read");
	a_latched_bits: assert property (s_wr(16'h0013) |=> ##1
		pll_ctrl.fund_powerdown == $past(reg_wdata[7], 2)
		&& pll_ctrl.fb_prescaler_rst == $past(reg_wdata[3], 2)
		&& pll_ctrl.ref_prescaler_rst == $past(reg_wdata[2], 2))
		else $error("latched reset bits wrong");
	a_fb_ratio: assert property (s_wr(16'h0020) |=> ##1
		pll_ctrl.fb_ratio == {1'b0, $past(reg_wdata[4:0], 2), 1'b0} + 7'h04)
		else $error("feedback ratio wrong");
	a_pd_ratio: assert property (s_wr(16'h0023) |=> ##1
		pll_ctrl.pd_clk_ratio == {$past(reg_wdata[3:0], 2), 2'b00})
		else $error("phase detector ratio wrong");
	a_pll_params: assert property (s_wr(16'h0022) |=> ##1
		pll_ctrl.ref_doubler_en == $past(reg_wdata[3], 2) && ($past(reg_wdata[7], 2)
		|| pll_ctrl.vco_high_range == $past(reg_wdata[2], 2)))
		else $error("pll parameters wrong");
	a_loop_ctrl: assert property (s_wr(16'h0100) |=> ##1
		pll_ctrl.loop_closed == $past(reg_wdata[0], 2)
		&& pll_ctrl.loop_invert == $past(reg_wdata[1], 2)
		&& pll_ctrl.slew_limit_en == $past(reg_wdata[3], 2)
		&& pll_ctrl.estimator_en == !$past(reg_wdata[4], 2)
		&& pll_ctrl.use_estimate == ($past(reg_wdata[0], 2) && !$past(reg_wdata[4], 2)))
		else $error("loop control wrong");
	a_clr_pulse: assert property (s_wr(16'h0012) |=>
		clr_pulse.all_bits == ($past(reg_wdata) & 8'hBF)
		&& clr_pulse.loop_filter_stage == $past(reg_wdata[2]))
		else $error("autoclear pulse wrong");
	a_clr_idle: assert property (!(reg_wr && reg_addr == 16'h0012) |=>
		clr_pulse.all_bits == 8'h00) else $error("autoclear pulse stuck");
	a_rsvd_read: assert property (reg_rd && reg_addr == 16'h0021 |=>
		reg_rdata == 8'h00) else $error("reserved slot read nonzero");
	a_tone_word: assert property (pll_ctrl.single_tone && $past(pll_ctrl.single_tone)
		&& $past(pll_ctrl.single_tone, 2) |-> dds_tuning_word == $past(first_tuning_word))
		else $error("single tone word wrong");
endmodule

// ===== tb/csp_regs_tb.sv
/* Self-checking bench for csp_regs.
 Drives the register port 2 ns after each rising edge. */
`timescale 1ns/1ps
module csp_regs_tb;
	logic clock = 0;
	logic sys_rst = 1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic vco_auto_high = 0;
	logic fb_prescaler_out = 0;
	logic ref_prescaler_out = 0;
	logic [47:0] first_tuning_word = 48'h123456789ABC;
	logic [47:0] loop_tuning_word = 48'hFEDCBA987654;
	logic [47:0] freq_estimate = 48'h665544332211;
	logic [7:0] reg_rdata;
	logic reg_rd_valid;
	csp_pkg::csp_ctrl_t pll_ctrl;
	csp_pkg::csp_clr_t clr_pulse;
	logic pd_clk_tick;
	logic [47:0] dds_tuning_word;
	logic [47:0] slew_limits;
	int err_count = 0;
	int total_checks = 0;
	int n;
	csp_regs u_csp_regs (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .vco_auto_high(vco_auto_high),
		.fb_prescaler_out(fb_prescaler_out), .ref_prescaler_out(ref_prescaler_out),
		.first_tuning_word(first_tuning_word), .loop_tuning_word(loop_tuning_word),
		.freq_estimate(freq_estimate), .pll_ctrl(pll_ctrl), .clr_pulse(clr_pulse),
		.pd_clk_tick(pd_clk_tick), .dds_tuning_word(dds_tuning_word),
		.slew_limits(slew_limits));
	always #25 clock = ~clock;
	task ck(input string nm, input logic [47:0] s, input logic [47:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#2;
	endtask
	// Returns once the controls show the write
	task wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
		cyc(1);
	endtask
	task rdc(input logic [15:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		ck("reg_rd_valid", reg_rd_valid, 1);
		ck("reg_rdata", reg_rdata, e);
		cyc(1);
	endtask
	task t_latched;
		rdc(16'h0013, 8'h00);
		wr(16'h0013, 8'hFF);
		cyc(10);
		rdc(16'h0013, 8'h8F);
		ck("fund_powerdown", pll_ctrl.fund_powerdown, 1);
		ck("presc_rst", {pll_ctrl.fb_prescaler_rst, pll_ctrl.ref_prescaler_rst}, 2'b11);
		ck("div_rst idle", {pll_ctrl.fb_divider_rst, pll_ctrl.ref_divider_rst}, 2'b00);
		fb_prescaler_out = 1;
		ref_prescaler_out = 1;
		cyc(3);
		ck("div_rst", {pll_ctrl.fb_divider_rst, pll_ctrl.ref_divider_rst}, 2'b11);
		wr(16'h0013, 8'h00);
		ck("fund_powerdown", pll_ctrl.fund_powerdown, 0);
		ck("presc_rst", {pll_ctrl.fb_prescaler_rst, pll_ctrl.ref_prescaler_rst}, 2'b00);
		ck("div_rst held", {pll_ctrl.fb_divider_rst, pll_ctrl.ref_divider_rst}, 2'b11);
		fb_prescaler_out = 0;
		ref_prescaler_out = 0;
		cyc(1);
		fb_prescaler_out = 1;
		ref_prescaler_out = 1;
		cyc(3);
		ck("div_rst", {pll_ctrl.fb_divider_rst, pll_ctrl.ref_divider_rst}, 2'b00);
	endtask
	task t_system_clock_input;
		wr(16'h0020, 8'h00);
		ck("fb_ratio", pll_ctrl.fb_ratio, 7'd4);
		wr(16'h0020, 8'hFF);
		ck("fb_ratio", pll_ctrl.fb_ratio, 7'd66);
		rdc(16'h0020, 8'h1F);
		rdc(16'h0021, 8'h00);
		wr(16'h0022, 8'h0C);
		ck("doubler vco", {pll_ctrl.ref_doubler_en, pll_ctrl.vco_high_range}, 2'b11);
		wr(16'h0022, 8'h08);
		ck("vco_high_range", pll_ctrl.vco_high_range, 0);
		vco_auto_high = 1;
		wr(16'h0022, 8'h80);
		ck("auto vco", {pll_ctrl.ref_doubler_en, pll_ctrl.vco_high_range}, 2'b01);
		rdc(16'h0022, 8'h84);
		vco_auto_high = 0;
		cyc(2);
		ck("auto vco", pll_ctrl.vco_high_range, 0);
	endtask
	task t_tick;
		wr(16'h0023, 8'h02);
		ck("pd_clk_ratio", pll_ctrl.pd_clk_ratio, 6'd8);
		for (n = 0; n < 20 && pd_clk_tick !== 1; n++) cyc(1);
		cyc(1);
		for (n = 1; n < 20 && pd_clk_tick !== 1; n++) cyc(1);
		ck("tick spacing", n, 8);
		wr(16'h0023, 8'h00);
		n = 0;
		repeat (20) begin
			cyc(1);
			n += pd_clk_tick;
		end
		ck("ticks at zero", n, 0);
	endtask
	task t_loop;
		rdc(16'h0115, 8'h11);
		rdc(16'h011A, 8'h66);
		wr(16'h0100, 8'h10);
		ck("estimator_en", pll_ctrl.estimator_en, 0);
		rdc(16'h0115, 8'h00);
		wr(16'h0100, 8'h01);
		ck("close", {pll_ctrl.loop_closed, pll_ctrl.use_estimate}, 2'b11);
		wr(16'h0100, 8'h11);
		ck("close", {pll_ctrl.loop_closed, pll_ctrl.use_estimate}, 2'b10);
		wr(16'h0100, 8'h02);
		ck("loop_invert", pll_ctrl.loop_invert, 1);
		wr(16'h0100, 8'h20);
		ck("single_tone", pll_ctrl.single_tone, 1);
		cyc(1);
		ck("dds tone", dds_tuning_word, first_tuning_word);
		wr(16'h0100, 8'h00);
		cyc(1);
		ck("dds loop", dds_tuning_word, loop_tuning_word);
		wr(16'h0012, 8'h06);
		wr(16'h0100, 8'hDF);
		rdc(16'h0100, 8'h1B);
		wr(16'h0100, 8'h08);
		ck("slew_limit_en", pll_ctrl.slew_limit_en, 1);
		for (int i = 0; i < 6; i++) wr(16'h0127 + 16'(i), 8'hA0 + 8'(i));
		ck("slew_limits", slew_limits, 48'hA5A4A3A2A1A0);
		rdc(16'h012C, 8'hA5);
	endtask
	task t_autoclr;
		for (int i = 0; i < 2; i++) begin
			reg_addr = 16'h0012;
			reg_wdata = i ? 8'hFF : 8'h06;
			reg_wr = 1;
			cyc(1);
			reg_wr = 0;
			ck("clr_pulse", clr_pulse.all_bits, reg_wdata & 8'hBF);
			ck("clr stages", {clr_pulse.loop_filter_stage, clr_pulse.comb_integrator_stage}, 2'b11);
			cyc(1);
			ck("clr_pulse", clr_pulse.all_bits, 8'h00);
		end
		rdc(16'h0012, 8'h00);
		wr(16'h0200, 8'h5A);
		rdc(16'h0200, 8'h00);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run is well under 1000 cycles
	initial begin
		#500000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		cyc(4);
		sys_rst = 0;
		t_latched();
		t_system_clock_input();
		t_tick();
		t_loop();
		t_autoclr();
		tally_and_finish();
	end
endmodule
bind csp_regs csp_regs_sva u_csp_regs_sva (.clock(clock), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .pll_ctrl(pll_ctrl),
	.clr_pulse(clr_pulse), .first_tuning_word(first_tuning_word),
	.dds_tuning_word(dds_tuning_word));
